/* apb_host_model.sv */
/*
  holds: an apb master standing for the controller that reads and
  writes the objects of the diagnostic store.
  assumes: one clock shared with the store; any number of wait states.
*/
`timescale 1ns/10ps
`default_nettype none
module apb_host_model (
  // clock
  input  wire logic        core_clk,
  // apb request
  output var  logic        psel,
  output var  logic        penable,
  output var  logic        pwrite,
  output var  logic [11:0] paddr,
  output var  logic [31:0] pwdata,
  // apb answer
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  // ------------------------------------------------------------
  // idle bus at time zero
  // ------------------------------------------------------------
  initial begin
    psel    <= 1'b0;
    penable <= 1'b0;
    pwrite  <= 1'b0;
    paddr   <= 12'h000;
    pwdata  <= 32'h0000_0000;
  end

  // ------------------------------------------------------------
  // one transfer, held until pready is seen at a rising edge
  // ------------------------------------------------------------
  task automatic xfer(input logic wr, input logic [11:0] a,
                      input logic [31:0] d, output logic [31:0] rd,
                      output logic err);
    // setup cycle
    @(posedge core_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    // access phase
    @(posedge core_clk);
    penable <= 1'b1;
    // no wait limit here: only the bench watchdog ends a hung wait
    do begin
      @(posedge core_clk);
    end while (pready !== 1'b1);
    // answer taken at the same edge at which pready is seen
    rd  = prdata;
    err = pslverr;
    // release; stale write data is not left on the bus
    psel    <= 1'b0;
    penable <= 1'b0;
    pwdata  <= ~d;
  endtask
endmodule
`default_nettype wire

/* diag_store_cfg.svh */
/*
  holds: register indices, command codes, field positions and reset
  values of the diagnostic object store.
  assumes: included by bare name wherever these values are needed.
*/
`ifndef DIAG_STORE_CFG_SVH
`define DIAG_STORE_CFG_SVH
// ----------------------------------------------------------------
// register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define IDX_DIAG_STATE   8'h18
`define IDX_DIAG_ACK     8'h19
`define IDX_OUT_POLICY   8'h24
`define IDX_IN_IMAGE     8'h25
`define IDX_OUT_IMAGE    8'h26
`define IDX_OUT_FALLBACK 8'h2F
`define IDX_IN_POLICY    8'h30
`define IDX_IN_FALLBACK  8'h31
`define IDX_STORE_STATUS 8'h3F
// ----------------------------------------------------------------
// acknowledge codes
// ----------------------------------------------------------------
`define ACK_PERMIT       8'h00
`define ACK_DELETE_ALL   8'h02
`define ACK_DELETE_LAST  8'h05
`define ACK_DELETE_BLOCK 8'h06
// ----------------------------------------------------------------
// priorities, flag bits, policy codes
// ----------------------------------------------------------------
`define PRIO_HIGH        8'h01
`define PRIO_MEDIUM      8'h02
`define PRIO_LOW         8'h03
`define FLAG_EXTENDED    0
`define FLAG_CONCURRENT  4
`define FLAG_NEW_LAYOUT  7
`define FLAG_RESV_MASK   8'h6E
`define POL_ZERO         16'h0000
`define POL_HOLD         16'h0001
`define POL_SUBST        16'h0002
`define POL_RESET        32'h0000_0000
`define FALLBACK_RESET   32'h0000_0000
`define STAT_BLOCKED     0
`define STAT_PASSIVATED  1
`define STAT_ACKED       2
`define STAT_VALID       3
`endif

/* diag_store_pkg.sv */
/*
  holds: the types carried between the store and its neighbours.
  assumes: nothing beyond a SystemVerilog compiler.
*/
`default_nettype none
package diag_store_pkg;
  // one incoming diagnostic event from the module's monitors
  typedef struct packed {
    logic        valid;    // one-cycle pulse
    logic [7:0]  prio;     // 01 high, 02 medium, 03 low
    logic [15:0] code;     // error code
    logic        extended; // detail record available
    logic        concur;   // further simultaneous events exist
  } diag_evt_t;
  // the single stored diagnostic entry
  typedef struct packed {
    logic [15:0] code;
    logic [7:0]  flags;
    logic [7:0]  prio;
  } diag_rec_t;
endpackage
`default_nettype wire

/* diagnostic_object_store.sv */
/*
  holds: the diagnostic entry store with acknowledge logic, the
  substitute-value policies and the process data images, as an
  APB slave.
  assumes: diagnostic events and the fault level come from logic on
  core_clk; process input, I/O error and bus reset come from pins.
*/
// Decided for this implementation: register access over APB.
`timescale 1ns/10ps
`default_nettype none
`include "diag_store_cfg.svh"

// What this block does
// - hold eight-bit flags byte in diagnostic record
// - bit 0 flags extended detail record
// - bit 4 flags concurrent diagnostic events
// - bit 7 marks extended record layout
// - priority 01 high, 02 medium, 03 low
// - store exactly one diagnostic message
// - higher priority message replaces stored one
// - lower priority message dropped while higher stored
// - acknowledge write with code 02, 05 or 06 clears entry, marks acknowledged
// - code 00 permits all messages again
// - code 02 deletes all pending messages
// - code 05 deletes last pending message
// - code 05 releases passivated output if fault gone
// - code 06 deletes all and blocks reporting
// - read-write output bus-reset policy array
// - outputs use fallback only under substitute policy
// - read-write input I/O-error policy array
// - inputs use fallback only under substitute policy
module diagnostic_object_store #(
  parameter int ADDR_W = 12,  // apb address width
  parameter int PD_W   = 32   // process data length in bits
) (
  // clock and reset
  input  wire logic                    core_clk,
  input  wire logic                    rst_n,
  // apb slave
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [ADDR_W-1:0]       paddr,
  input  wire logic [31:0]             pwdata,
  output var  logic [31:0]             prdata,
  output logic                         pready,
  output var  logic                    pslverr,
  // diagnostic sources
  input  wire diag_store_pkg::diag_evt_t diagEvt,
  input  wire logic                    faultActive,
  // process data
  input  wire logic [PD_W-1:0]         appOutData,
  input  wire logic [PD_W-1:0]         ioInPins,
  input  wire logic                    ioErrorPin,
  input  wire logic                    busResetPin,
  output var  logic [PD_W-1:0]         outImage,
  output var  logic [PD_W-1:0]         inImage
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // register index from a byte address, all ones if misaligned
  function automatic logic [7:0] regIdx(input logic [ADDR_W-1:0] a);
    regIdx = (a[1:0] == 2'b00) ? a[9:2] : 8'hFF;
  endfunction

  // policy element 0 governs the whole image
  function automatic logic [PD_W-1:0] applyPolicy(
    input logic [15:0]     pol,
    input logic [PD_W-1:0] subst,
    input logic [PD_W-1:0] held
  );
    if (pol == `POL_SUBST) begin
      applyPolicy = subst;
    end else if (pol == `POL_HOLD) begin
      applyPolicy = held;
    end else begin
      applyPolicy = '0;
    end
  endfunction

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [PD_W-1:0] ioInMeta_q;   // first stage, read by stage two
  logic [PD_W-1:0] ioIn_q;       // synchronised process inputs
  logic            ioErrMeta_q;  // first stage
  logic            ioErr_q;      // synchronised i/o error
  logic            busRstMeta_q; // first stage
  logic            busRst_q;     // synchronised bus reset

  // two flops for each pin level
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ioInMeta_q   <= '0;
      ioIn_q       <= '0;
      ioErrMeta_q  <= 1'b0;
      ioErr_q      <= 1'b0;
      busRstMeta_q <= 1'b0;
      busRst_q     <= 1'b0;
    end else begin
      ioInMeta_q   <= ioInPins;
      ioIn_q       <= ioInMeta_q;
      ioErrMeta_q  <= ioErrorPin;
      ioErr_q      <= ioErrMeta_q;
      busRstMeta_q <= busResetPin;
      busRst_q     <= busRstMeta_q;
    end
  end

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  wire logic       setupPh = psel && !penable;   // setup cycle
  wire logic       accPh   = psel && penable;    // access cycle
  wire logic [7:0] idx     = regIdx(paddr);      // register index
  wire logic       wrAcc   = accPh && pwrite;    // write commits
  wire logic       hitDiag = (idx == `IDX_DIAG_STATE);
  wire logic       hitAck  = (idx == `IDX_DIAG_ACK);
  wire logic       hitOPol = (idx == `IDX_OUT_POLICY);
  wire logic       hitIImg = (idx == `IDX_IN_IMAGE);
  wire logic       hitOImg = (idx == `IDX_OUT_IMAGE);
  wire logic       hitOFb  = (idx == `IDX_OUT_FALLBACK);
  wire logic       hitIPol = (idx == `IDX_IN_POLICY);
  wire logic       hitIFb  = (idx == `IDX_IN_FALLBACK);
  wire logic       hitStat = (idx == `IDX_STORE_STATUS);
  wire logic       mapped  = hitDiag | hitAck | hitOPol | hitIImg |
                             hitOImg | hitOFb | hitIPol | hitIFb |
                             hitStat;
  // zero wait states: answer in the first access cycle
  assign pready = accPh;

  // ----------------------------------------------------------------
  // acknowledge command decode
  // ----------------------------------------------------------------
  wire logic [7:0] ackCode = pwdata[7:0];
  wire logic ackWr    = wrAcc && hitAck;
  wire logic ackPerm  = ackWr && (ackCode == `ACK_PERMIT);
  wire logic ackAll   = ackWr && (ackCode == `ACK_DELETE_ALL);
  wire logic ackLast  = ackWr && (ackCode == `ACK_DELETE_LAST);
  wire logic ackBlock = ackWr && (ackCode == `ACK_DELETE_BLOCK);
  // depth one: all, last and block delete the same entry
  wire logic ackClr   = ackAll | ackLast | ackBlock;
  // unknown codes decode to nothing at all
  wire logic ackAny   = ackPerm | ackClr;

  // ----------------------------------------------------------------
  // diagnostic entry store
  // ----------------------------------------------------------------
  diag_store_pkg::diag_rec_t rec_q;   // the single entry
  diag_store_pkg::diag_rec_t rec_d;
  logic valid_q;      // entry holds a message
  logic blocked_q;    // reporting blocked by code 06
  logic acked_q;      // last entry was acknowledged
  logic passive_q;    // safety output passivated

  // legal priority only
  wire logic prioOk = (diagEvt.prio == `PRIO_HIGH) ||
                      (diagEvt.prio == `PRIO_MEDIUM) ||
                      (diagEvt.prio == `PRIO_LOW);
  // smaller code is higher priority; equal refreshes the entry
  wire logic outranks = !valid_q ||
                        (diagEvt.prio <= rec_q.prio);
  // an event never stores while reporting is blocked
  wire logic takeEvt = diagEvt.valid && prioOk && !blocked_q &&
                       outranks;

  // flags byte of the incoming event
  always_comb begin
    rec_d       = rec_q;
    rec_d.prio  = diagEvt.prio;
    rec_d.code  = diagEvt.code;
    rec_d.flags = '0;
    rec_d.flags[`FLAG_EXTENDED]   = diagEvt.extended;
    rec_d.flags[`FLAG_CONCURRENT] = diagEvt.concur;
    rec_d.flags[`FLAG_NEW_LAYOUT] = 1'b1;
  end

  // entry register: a new event wins over a clear in the same cycle
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rec_q   <= '0;
      valid_q <= 1'b0;
    end else if (takeEvt) begin
      rec_q   <= rec_d;
      valid_q <= 1'b1;
    end else if (ackClr) begin
      rec_q   <= '0;
      valid_q <= 1'b0;
    end
  end

  // acknowledged mark, cleared by the next stored message
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      acked_q <= 1'b0;
    end else if (takeEvt) begin
      acked_q <= 1'b0;
    end else if (ackClr) begin
      acked_q <= 1'b1;
    end
  end

  // reporting block: set by 06, lifted by 00
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      blocked_q <= 1'b0;
    end else if (ackBlock) begin
      blocked_q <= 1'b1;
    end else if (ackPerm) begin
      blocked_q <= 1'b0;
    end
  end

  // passivation: high-priority message passivates, 05 releases
  wire logic passSet = takeEvt && (diagEvt.prio == `PRIO_HIGH);
  wire logic passRel = ackLast && !faultActive;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      passive_q <= 1'b0;
    end else if (passSet) begin
      passive_q <= 1'b1;
    end else if (passRel) begin
      passive_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // policy and fallback registers
  // ----------------------------------------------------------------
  logic [31:0]     outPol_q; // two 16-bit output policy elements
  logic [31:0]     inPol_q;  // two 16-bit input policy elements
  logic [PD_W-1:0] outFb_q;  // output fallback value
  logic [PD_W-1:0] inFb_q;   // input fallback value

  // software writes take effect in the access cycle
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      outPol_q <= `POL_RESET;
      inPol_q  <= `POL_RESET;
      outFb_q  <= PD_W'(`FALLBACK_RESET);
      inFb_q   <= PD_W'(`FALLBACK_RESET);
    end else if (wrAcc) begin
      if (hitOPol) begin
        outPol_q <= pwdata;
      end
      if (hitIPol) begin
        inPol_q <= pwdata;
      end
      if (hitOFb) begin
        outFb_q <= pwdata[PD_W-1:0];
      end
      if (hitIFb) begin
        inFb_q <= pwdata[PD_W-1:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // process data images
  // ----------------------------------------------------------------
  wire logic [15:0] outPolSel = outPol_q[15:0]; // element 0
  wire logic [15:0] inPolSel  = inPol_q[15:0];  // element 0
  // output: bus reset policy first, then passivation, then app
  wire logic [PD_W-1:0] outNext =
    busRst_q  ? applyPolicy(outPolSel, outFb_q, outImage) :
    passive_q ? '0 : appOutData;
  // input: i/o error policy, otherwise the synchronised pins
  wire logic [PD_W-1:0] inNext =
    ioErr_q ? applyPolicy(inPolSel, inFb_q, inImage) :
    ioIn_q;

  // image registers drive the ports directly
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      outImage <= '0;
      inImage  <= '0;
    end else begin
      outImage <= outNext;
      inImage  <= inNext;
    end
  end

  // ----------------------------------------------------------------
  // read mux and bus answer
  // ----------------------------------------------------------------
  wire logic [31:0] statWord = {28'h0000000, valid_q, acked_q,
                                passive_q, blocked_q};
  wire logic [31:0] rdMux =
    hitDiag ? rec_q :
    hitOPol ? outPol_q :
    hitIImg ? 32'(inImage) :
    hitOImg ? 32'(outImage) :
    hitOFb  ? 32'(outFb_q) :
    hitIPol ? inPol_q :
    hitIFb  ? 32'(inFb_q) :
    hitStat ? statWord : 32'h0000_0000;

  // read data and error are captured in the setup cycle
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (setupPh) begin
      prdata  <= pwrite ? 32'h0000_0000 : rdMux;
      // writes to read-only images are refused as errors
      pslverr <= !mapped || (pwrite && (hitDiag || hitIImg ||
                 hitOImg || hitStat));
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence seqBlockAck;
    ackBlock && !takeEvt;
  endsequence
  sequence seqLegalEvt;
    diagEvt.valid && prioOk;
  endsequence

  a_store_replace: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    seqLegalEvt and (valid_q && !blocked_q &&
    diagEvt.prio < rec_q.prio)
    |=> rec_q.prio == $past(diagEvt.prio) && valid_q)
    else $error("higher priority did not replace entry");
  a_lower_drop: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    valid_q && diagEvt.valid && diagEvt.prio > rec_q.prio && !ackClr
    |=> $stable(rec_q))
    else $error("lower priority message altered entry");
  a_flags_layout: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    valid_q |-> rec_q.flags[`FLAG_NEW_LAYOUT] &&
    (rec_q.flags & `FLAG_RESV_MASK) == 8'h00)
    else $error("flags byte malformed");
  a_prio_range: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    valid_q |-> rec_q.prio >= `PRIO_HIGH &&
    rec_q.prio <= `PRIO_LOW)
    else $error("stored priority out of range");
  a_ack_clear: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    ackClr && !takeEvt |=> !valid_q && acked_q)
    else $error("acknowledge did not clear entry");
  a_ack_ignore: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    ackWr && !ackAny && !takeEvt
    |=> $stable(rec_q) && $stable(blocked_q) &&
    $stable(acked_q) && $stable(passive_q))
    else $error("undefined acknowledge code acted");
  a_block_hold: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    seqBlockAck ##1 (!ackPerm)[*2] |=> !valid_q)
    else $error("message stored while reporting blocked");
  a_pass_release: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    passive_q && ackLast && !faultActive && !passSet
    |=> !passive_q ##1
    ($past(busRst_q) || outImage == $past(appOutData)))
    else $error("passivated output not released");
  a_pass_zero: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    passive_q && !busRst_q |=> outImage == '0)
    else $error("passivated output driven");
  a_out_subst: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    busRst_q && outPolSel != `POL_SUBST && outPolSel != `POL_HOLD
    |=> outImage == '0)
    else $error("output fallback used without policy");
  a_in_subst: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    ioErr_q && inPolSel == `POL_SUBST
    |=> inImage == $past(inFb_q))
    else $error("input fallback not applied");
  a_apb_answer: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    setupPh && !(pwrite) && hitStat
    |=> pready && prdata == $past(statWord))
    else $error("status read answered wrongly");

endmodule
`default_nettype wire

/* diagnostic_object_store_test.sv */
/*
  holds: the self-checking testbench of the diagnostic object store.
  assumes: apb_host_model drives the register bus; 250 MHz clock.
*/
`timescale 1ns/10ps
`default_nettype none
`include "diag_store_cfg.svh"
`define CHK(got, exp) \
  begin \
    comparisons++; \
    if ((got) !== (exp)) begin \
      errors++; \
      $display("wrong value at %0t: got %h expected %h", $time, got, exp); \
    end \
  end
module diagnostic_object_store_test;
  // ------------------------------------------------------------
  // signals
  // ------------------------------------------------------------
  logic                      core_clk;    // 4 ns clock
  logic                      rst_n;       // async reset
  logic                      psel, penable, pwrite, pready, pslverr;
  logic [11:0]               paddr;       // byte address
  logic [31:0]               pwdata, prdata;
  diag_store_pkg::diag_evt_t diagEvt;     // event pulse
  logic                      faultActive; // fault still present
  logic [31:0]               appOutData, ioInPins, outImage, inImage;
  logic                      ioErrorPin, busResetPin;
  logic [31:0]               rdv;         // last read data
  logic                      errv;        // last error flag
  int                        errors, comparisons;

  // ------------------------------------------------------------
  // instances
  // ------------------------------------------------------------
  diagnostic_object_store diagnostic_object_store_i (
    .core_clk(core_clk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .diagEvt(diagEvt), .faultActive(faultActive),
    .appOutData(appOutData), .ioInPins(ioInPins),
    .ioErrorPin(ioErrorPin), .busResetPin(busResetPin),
    .outImage(outImage), .inImage(inImage));
  apb_host_model apb_host_model_i (
    .core_clk(core_clk), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr));

  // clock
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  // register access by index
  task automatic acc(input logic wr, input logic [7:0] idx,
                     input logic [31:0] d);
    apb_host_model_i.xfer(wr, {2'b00, idx, 2'b00}, d, rdv, errv);
  endtask
  // one-cycle diagnostic event
  task automatic evt(input logic [7:0] p, input logic [15:0] c,
                     input logic e, input logic k);
    @(posedge core_clk);
    diagEvt <= '{1'b1, p, c, e, k};
    @(posedge core_clk);
    diagEvt <= '0;
  endtask
  // let n edges pass, then look at settled outputs
  task automatic wt(input int n);
    repeat (n) @(posedge core_clk);
    @(negedge core_clk);
  endtask
  // expected diagnostic word: code, flags, priority
  function automatic logic [31:0] dw(input logic [15:0] c,
      input logic e, input logic k, input logic [7:0] p);
    return {c, 1'b1, 2'b00, k, 3'b000, e, p};
  endfunction

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_map();
    acc(0, `IDX_OUT_POLICY, 32'h0); `CHK(rdv, `POL_RESET)
    acc(0, `IDX_DIAG_STATE, 32'h0); `CHK(rdv, 32'h0)
    acc(0, 8'h3E, 32'h0); `CHK(errv, 1'b1)
    apb_host_model_i.xfer(0, 12'h061, 32'h0, rdv, errv);
    `CHK(errv, 1'b1)
  endtask
  task automatic t_prio();
    evt(`PRIO_MEDIUM, 16'hA001, 1'b1, 1'b0);
    acc(0, `IDX_DIAG_STATE, 32'h0);
    `CHK(rdv, dw(16'hA001, 1'b1, 1'b0, `PRIO_MEDIUM))
    `CHK(rdv[15], 1'b1)
    evt(`PRIO_LOW, 16'hB002, 1'b0, 1'b0);
    evt(8'h04, 16'hB003, 1'b0, 1'b0);
    acc(0, `IDX_DIAG_STATE, 32'h0);
    `CHK(rdv, dw(16'hA001, 1'b1, 1'b0, `PRIO_MEDIUM))
    faultActive <= 1'b1;
    evt(`PRIO_HIGH, 16'hC003, 1'b0, 1'b1);
    acc(0, `IDX_DIAG_STATE, 32'h0);
    `CHK(rdv, dw(16'hC003, 1'b0, 1'b1, `PRIO_HIGH))
    `CHK(rdv[12], 1'b1)
    acc(0, `IDX_STORE_STATUS, 32'h0); `CHK(rdv[3:0], 4'hA)
  endtask
  task automatic t_ack();
    appOutData <= 32'h0F0F_1234;
    acc(1, `IDX_DIAG_ACK, 32'h0000_0007);
    acc(0, `IDX_DIAG_STATE, 32'h0);
    `CHK(rdv, dw(16'hC003, 1'b0, 1'b1, `PRIO_HIGH))
    wt(1); `CHK(outImage, 32'h0)
    acc(1, `IDX_DIAG_ACK, `ACK_DELETE_LAST);
    acc(0, `IDX_DIAG_STATE, 32'h0); `CHK(rdv, 32'h0)
    acc(0, `IDX_STORE_STATUS, 32'h0); `CHK(rdv[3:0], 4'h6)
    faultActive <= 1'b0;
    acc(1, `IDX_DIAG_ACK, `ACK_DELETE_LAST);
    acc(0, `IDX_STORE_STATUS, 32'h0); `CHK(rdv[3:0], 4'h4)
    wt(1); `CHK(outImage, 32'h0F0F_1234)
  endtask
  task automatic t_block();
    evt(`PRIO_LOW, 16'hD004, 1'b0, 1'b0);
    acc(1, `IDX_DIAG_ACK, `ACK_DELETE_ALL);
    acc(0, `IDX_DIAG_STATE, 32'h0); `CHK(rdv, 32'h0)
    acc(1, `IDX_DIAG_ACK, `ACK_DELETE_BLOCK);
    evt(`PRIO_MEDIUM, 16'hE005, 1'b0, 1'b0);
    acc(0, `IDX_DIAG_STATE, 32'h0); `CHK(rdv, 32'h0)
    acc(0, `IDX_STORE_STATUS, 32'h0); `CHK(rdv[0], 1'b1)
    acc(1, `IDX_DIAG_ACK, `ACK_PERMIT);
    evt(`PRIO_LOW, 16'hE005, 1'b0, 1'b0);
    acc(0, `IDX_DIAG_STATE, 32'h0);
    `CHK(rdv, dw(16'hE005, 1'b0, 1'b0, `PRIO_LOW))
    acc(0, `IDX_DIAG_ACK, 32'h0); `CHK(rdv, 32'h0)
  endtask
  task automatic t_policy();
    acc(1, `IDX_OUT_POLICY, {16'h0000, `POL_SUBST});
    acc(0, `IDX_OUT_POLICY, 32'h0); `CHK(rdv, 32'h0000_0002)
    acc(1, `IDX_OUT_FALLBACK, 32'h5A5A_A5A5);
    busResetPin <= 1'b1;
    wt(4); `CHK(outImage, 32'h5A5A_A5A5)
    acc(1, `IDX_OUT_POLICY, {16'h0000, `POL_HOLD});
    acc(1, `IDX_OUT_FALLBACK, 32'h1111_2222);
    wt(2); `CHK(outImage, 32'h5A5A_A5A5)
    acc(1, `IDX_OUT_POLICY, 32'h0);
    wt(2); `CHK(outImage, 32'h0)
    busResetPin <= 1'b0;
    acc(1, `IDX_IN_POLICY, {16'h0000, `POL_SUBST});
    acc(0, `IDX_IN_POLICY, 32'h0); `CHK(rdv, 32'h0000_0002)
    acc(1, `IDX_IN_FALLBACK, 32'h3C3C_C3C3);
    ioInPins   <= 32'h1234_5678;
    ioErrorPin <= 1'b1;
    wt(4); `CHK(inImage, 32'h3C3C_C3C3)
    acc(1, `IDX_IN_POLICY, 32'h0);
    wt(2); `CHK(inImage, 32'h0)
    ioErrorPin <= 1'b0;
    wt(4); `CHK(inImage, 32'h1234_5678)
    acc(0, `IDX_IN_IMAGE, 32'h0); `CHK(rdv, 32'h1234_5678)
    acc(1, `IDX_IN_IMAGE, 32'h0); `CHK(errv, 1'b1)
    acc(0, `IDX_OUT_IMAGE, 32'h0); `CHK(rdv, 32'h0F0F_1234)
  endtask

  // ------------------------------------------------------------
  // verdict and run control
  // ------------------------------------------------------------
  task automatic stop_test();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // watchdog against a hung handshake
  initial begin
    repeat (5000) @(posedge core_clk);
    errors++;
    stop_test();
  end
  // main sequence
  initial begin
    errors      = 0;
    comparisons = 0;
    rst_n       <= 1'b0;
    diagEvt     <= '0;
    faultActive <= 1'b0;
    appOutData  <= 32'h0;
    ioInPins    <= 32'h0;
    ioErrorPin  <= 1'b0;
    busResetPin <= 1'b0;
    repeat (4) @(posedge core_clk);
    rst_n <= 1'b1;
    t_map();
    t_prio();
    t_ack();
    t_block();
    t_policy();
    stop_test();
  end
endmodule
`default_nettype wire
